// File: tb/dmc_dram_model.sv
// memory bank model: takes row address on a row strobe fall, column address on a column fall
`timescale 1ns/1ps
module dmc_dram_model
   import dmc_pkg::*;
(
   // clock
   input  wire logic              i_ref_clk,
   // memory side of the controller
   input  wire logic [ADDR_W-1:0] i_mem_addr,
   input  wire logic [BANKS-1:0]  i_row_strobe_n,
   input  wire logic              i_col_strobe_n,
   // captured addresses
   output logic [ADDR_W-1:0]      o_row_q,
   output logic [ADDR_W-1:0]      o_col_q
);
   logic row_idle_q = 1'b1;
   logic col_idle_q = 1'b1;
   always_ff @(posedge i_ref_clk)
   begin
      row_idle_q <= &i_row_strobe_n;
      col_idle_q <= i_col_strobe_n;
      if (row_idle_q && !(&i_row_strobe_n))
         o_row_q <= i_mem_addr;
      if (col_idle_q && !i_col_strobe_n)
         o_col_q <= i_mem_addr;
   end
endmodule

// File: tb/dmc_dynamic_memory_ctrl_bench.sv
// self-checking bench for the address and refresh controller
`timescale 1ns/1ps
module dmc_dynamic_memory_ctrl_bench;
   import dmc_pkg::*;
   logic              clk   = 1'b0;
   logic              rstn  = 1'b0;
   dmc_addr_s         a     = '0;
   dmc_addr_s         e;
   logic              len   = 1'b0;
   logic [1:0]        src   = 2'h0;
   logic              rfq_n = 1'b1;
   logic              rsi_n = 1'b1;
   logic              csi_n = 1'b1;
   logic              clr   = 1'b0;
   logic              top   = 1'b0;
   logic [ADDR_W-1:0] maddr;
   logic [ADDR_W-1:0] rseen;
   logic [ADDR_W-1:0] cseen;
   logic [BANKS-1:0]  rs_n;
   logic              cs_n;
   logic              tc;
   logic [15:0]       lf    = 16'h9422;
   logic [ADDR_W-1:0] cnt;
   int                n_errors = 0;
   int                n_tests  = 0;

   dmc_dynamic_memory_ctrl uut (.i_ref_clk(clk), .i_rstn(rstn), .i_row_addr(a.row),
      .i_col_addr(a.col), .i_bank_sel(a.bank), .i_latch_en(len), .i_src_sel(src),
      .i_refresh_request_n(rfq_n), .i_row_strobe_in_n(rsi_n), .i_col_strobe_in_n(csi_n),
      .i_counter_clear(clr), .i_top_addr_count_select(top), .o_mem_addr(maddr),
      .o_row_strobe_n(rs_n), .o_col_strobe_n(cs_n), .o_terminal_count(tc));
   dmc_dram_model mem (.i_ref_clk(clk), .i_mem_addr(maddr), .i_row_strobe_n(rs_n),
      .i_col_strobe_n(cs_n), .o_row_q(rseen), .o_col_q(cseen));

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [ADDR_W-1:0] nxt(input logic [ADDR_W-1:0] c, input logic h);
      return (c == (h ? TC_HALF : TC_FULL)) ? CNT_RESET : c + CNT_ONE;
   endfunction
   // expected bank strobes outside refresh: only the selected bank goes low
   function automatic logic [BANKS-1:0] bank_exp(input logic [BANK_SEL_W-1:0] b);
      return ~(4'h1 << b);
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one refresh row: strobe low for one edge, then count and address settle
   task automatic rstrobe();
      rsi_n = 1'b0;
      #1;
      chk(rs_n, STROBES_ALL);
      chk(cs_n, 1'b1);
      cyc(1);
      rsi_n = 1'b1;
      cyc(2);
      cnt = nxt(cnt, top);
      chk(maddr, cnt);
      chk(tc, cnt == (top ? TC_HALF : TC_FULL));
   endtask

   initial
   forever #12.5 clk = ~clk;
   initial
   begin
      #200000;
      n_errors++;
      test_done();
   end
   initial
   begin
      cyc(3);
      rstn = 1'b1;
      chk(maddr, CNT_RESET);
      for (int i = 0; i < 8; i++)
      begin
         lf = lfsr(lf);
         a = {lf, lf[3:2]};
         a.bank = i[1:0];
         e = a;
         len = 1'b1;
         cyc(1);
         len = 1'b0;
         lf = lfsr(lf);
         a = {lf, lf[5:4]};
         src = i[2] ? 2'h3 : 2'h0;
         cyc(1);
         chk(maddr, e.row);
         rsi_n = 1'b0;
         #1;
         chk(rs_n, bank_exp(e.bank));
         cyc(1);
         src = DMC_SRC_COL;
         cyc(1);
         chk(rseen, e.row);
         csi_n = 1'b0;
         #1;
         chk(cs_n, 1'b0);
         cyc(1);
         chk(cseen, e.col);
         rsi_n = 1'b1;
         csi_n = 1'b1;
         cyc(1);
      end
      // column select stays applied: refresh must override it
      csi_n = 1'b0;
      rfq_n = 1'b0;
      for (int m = 0; m < 2; m++)
      begin
         top = m[0];
         clr = 1'b1;
         cyc(1);
         clr = 1'b0;
         cyc(1);
         cnt = CNT_RESET;
         chk(maddr, cnt);
         repeat (m ? 130 : 258) rstrobe();
      end
      rfq_n = 1'b1;
      csi_n = 1'b1;
      rsi_n = 1'b0;
      cyc(1);
      rsi_n = 1'b1;
      cyc(1);
      rfq_n = 1'b0;
      csi_n = 1'b0;
      cyc(1);
      rstrobe();
      // counter source chosen by the host outside refresh
      rfq_n = 1'b1;
      csi_n = 1'b1;
      src = DMC_SRC_REFRESH;
      cyc(2);
      chk(maddr, cnt);
      test_done();
   end
endmodule

// File: verilog/dmc_dynamic_memory_ctrl.sv
// file: address latches, address multiplexer, bank strobe decoder and refresh control
`timescale 1ns/1ps
module dmc_dynamic_memory_ctrl
   import dmc_pkg::*;
(
   // clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rstn,
   // host address
   input  wire logic [ADDR_W-1:0]     i_row_addr,
   input  wire logic [ADDR_W-1:0]     i_col_addr,
   input  wire logic [BANK_SEL_W-1:0] i_bank_sel,
   input  wire logic                  i_latch_en,
   input  wire logic [1:0]            i_src_sel,
   // host control
   input  wire logic                  i_refresh_request_n,
   input  wire logic                  i_row_strobe_in_n,
   input  wire logic                  i_col_strobe_in_n,
   input  wire logic                  i_counter_clear,
   input  wire logic                  i_top_addr_count_select,
   // memory side
   output logic [ADDR_W-1:0]          o_mem_addr,
   output logic [BANKS-1:0]           o_row_strobe_n,
   output logic                       o_col_strobe_n,
   output logic                       o_terminal_count
);
   dmc_addr_s        addr_q;
   logic [ADDR_W-1:0] cnt;
   logic              cnt_tc;
   logic              rs_q;
   logic              refresh;
   logic              rs_rise;
   logic              half_range;
   dmc_src_e          src;

   assign refresh = !i_refresh_request_n;
   assign src     = dmc_src_e'(i_src_sel);
   // top address bit only selects the short range while refresh is requested
   assign half_range = refresh && i_top_addr_count_select;
   // advance on the end of each refresh row strobe so the row just refreshed
   // stays on the address lines for the whole strobe
   assign rs_rise = refresh && !rs_q && i_row_strobe_in_n;

   function automatic logic [BANKS-1:0] bank_decode(input logic [BANK_SEL_W-1:0] sel);
      logic [BANKS-1:0] onehot;
      onehot = '0;
      onehot[sel] = 1'b1;
      return onehot;
   endfunction

   // latches load on each rising clock edge while enabled, then hold
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         addr_q <= '0;
      else if (i_latch_en)
      begin
         addr_q.row  <= i_row_addr;
         addr_q.col  <= i_col_addr;
         addr_q.bank <= i_bank_sel;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         rs_q <= 1'b1;
      else
         rs_q <= i_row_strobe_in_n;
   end

   dmc_refresh_counter #(
      .WIDTH (ADDR_W)
   ) u_counter (
      .i_ref_clk    (i_ref_clk),
      .i_rstn       (i_rstn),
      .i_clear      (i_counter_clear),
      .i_advance    (rs_rise),
      .i_half_range (half_range),
      .o_count      (cnt),
      .o_terminal   (cnt_tc)
   );

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         o_terminal_count <= 1'b0;
      else
         o_terminal_count <= cnt_tc;
   end

   // address path registered; refresh forces the counter source
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn)
         o_mem_addr <= CNT_RESET;
      else if (refresh)
         o_mem_addr <= cnt;
      else
      begin
         case (src)
            DMC_SRC_ROW:     o_mem_addr <= addr_q.row;
            DMC_SRC_COL:     o_mem_addr <= addr_q.col;
            DMC_SRC_REFRESH: o_mem_addr <= cnt;
            default:         o_mem_addr <= addr_q.row;
         endcase
      end
   end

   // strobes stay combinational to keep skew to the input strobe minimal
   always_comb
   begin
      o_row_strobe_n = STROBES_IDLE;
      if (!i_row_strobe_in_n)
      begin
         if (refresh)
            o_row_strobe_n = STROBES_ALL;
         else
            o_row_strobe_n = ~bank_decode(addr_q.bank);
      end
   end

   assign o_col_strobe_n = refresh ? 1'b1 : i_col_strobe_in_n;

   property p_single_bank;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (!i_row_strobe_in_n && !refresh) |-> $onehot(~o_row_strobe_n);
   endproperty
   a_single_bank: assert property (p_single_bank) else $error("not one bank strobe");

   property p_all_banks;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (!i_row_strobe_in_n && refresh) |-> (o_row_strobe_n == STROBES_ALL);
   endproperty
   a_all_banks: assert property (p_all_banks) else $error("refresh strobe not to all banks");

   property p_col_inhibit;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      refresh |-> o_col_strobe_n;
   endproperty
   a_col_inhibit: assert property (p_col_inhibit) else $error("column strobe during refresh");

   property p_refresh_addr;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (refresh && !i_counter_clear && !rs_rise) |=> (o_mem_addr == $past(cnt));
   endproperty
   a_refresh_addr: assert property (p_refresh_addr) else $error("refresh address wrong");

   property p_advance;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (rs_rise && !i_counter_clear && !cnt_tc) |=> (cnt == $past(cnt) + CNT_ONE);
   endproperty
   a_advance: assert property (p_advance) else $error("counter did not advance");

   property p_wrap;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (rs_rise && cnt_tc) |=> (cnt == CNT_RESET);
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");

   property p_half_tc;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (half_range && cnt == TC_HALF) |=> o_terminal_count;
   endproperty
   a_half_tc: assert property (p_half_tc) else $error("no terminal count at 128");

   property p_tc;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (!half_range && cnt != TC_FULL) |=> !o_terminal_count;
   endproperty
   a_tc: assert property (p_tc) else $error("early terminal count");

   property p_clear;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_counter_clear |=> (cnt == CNT_RESET);
   endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");

   property p_latch;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_latch_en ##1 !i_latch_en [*2] ##1 (!refresh && src == DMC_SRC_COL))
         |=> (o_mem_addr == $past(i_col_addr, 4));
   endproperty
   a_latch: assert property (p_latch) else $error("column latch not presented");

   property p_hold_count;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (!refresh && !i_counter_clear) |=> (cnt == $past(cnt));
   endproperty
   a_hold_count: assert property (p_hold_count) else $error("counter moved outside refresh");

   property p_full_tc;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      (!half_range && cnt == TC_FULL) |=> o_terminal_count;
   endproperty
   a_full_tc: assert property (p_full_tc) else $error("no terminal count at 256");

   property p_col_pass;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      !refresh |-> (o_col_strobe_n == i_col_strobe_in_n);
   endproperty
   a_col_pass: assert property (p_col_pass) else $error("column strobe not passed");

   property p_row_idle;
      @(posedge i_ref_clk) disable iff (!i_rstn)
      i_row_strobe_in_n |-> (o_row_strobe_n == STROBES_IDLE);
   endproperty
   a_row_idle: assert property (p_row_idle) else $error("bank strobe without row strobe");
endmodule

// File: verilog/dmc_pkg.sv
// package: constants and carriers for the dynamic memory address and refresh controller
package dmc_pkg;
   localparam int ADDR_W     = 8;
   localparam int BANKS      = 4;
   localparam int BANK_SEL_W = 2;
   localparam logic [ADDR_W-1:0] CNT_RESET    = 8'h00;
   localparam logic [ADDR_W-1:0] CNT_ONE      = 8'h01;
   localparam logic [ADDR_W-1:0] TC_FULL      = 8'hFF;
   localparam logic [ADDR_W-1:0] TC_HALF      = 8'h7F;
   localparam int               TOP_BIT      = 7;
   localparam logic [BANKS-1:0] STROBES_IDLE = 4'hF;
   localparam logic [BANKS-1:0] STROBES_ALL  = 4'h0;

   // address source selection
   typedef enum logic [1:0] {
      DMC_SRC_ROW,
      DMC_SRC_COL,
      DMC_SRC_REFRESH,
      DMC_SRC_RSVD
   } dmc_src_e;

   // latched host address: row half, column half, bank select
   typedef struct packed {
      logic [ADDR_W-1:0]     row;
      logic [ADDR_W-1:0]     col;
      logic [BANK_SEL_W-1:0] bank;
   } dmc_addr_s;
endpackage

// File: verilog/dmc_refresh_counter.sv
// file: refresh row counter with clear and selectable terminal count
`timescale 1ns/1ps
module dmc_refresh_counter
   import dmc_pkg::*;
#(
   parameter int WIDTH = ADDR_W
)
(
   // clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rstn,
   // control
   input  wire logic             i_clear,
   input  wire logic             i_advance,
   input  wire logic             i_half_range,
   // state
   output logic [WIDTH-1:0]      o_count,
   output logic                  o_terminal
);
   // terminal values are fixed at the address width, so other widths cannot be served
   if (WIDTH != ADDR_W)
   begin
      $error("refresh counter width must equal the address width");
   end

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic [WIDTH-1:0] limit;

   assign limit = i_half_range ? TC_HALF : TC_FULL;
   assign o_terminal = (count_q == limit);
   assign o_count = count_q;

   always_comb
   begin
      count_d = count_q;
      if (i_advance)
         count_d = o_terminal ? CNT_RESET : count_q + CNT_ONE;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rstn || i_clear)
         count_q <= CNT_RESET;
      else
         count_q <= count_d;
   end
endmodule
